// ==== verilog/fru_pkg.sv ====
// Package for the single-operand data-memory execution datapath.
// Assumes one instruction clock and a synchronous active-high core reset.
package fru_pkg;

	localparam int FRU_DATA_W = 8;
	localparam int FRU_ADDR_W = 7;
	localparam int FRU_MEM_DEPTH = 128;
	localparam logic [7:0] FRU_ZERO_BYTE = 8'h00;
	localparam logic [7:0] FRU_ONE_BYTE = 8'h01;
	localparam logic [7:0] FRU_ACC_RESET = 8'h00;
	localparam logic FRU_ZERO_FLAG_RESET = 1'b0;
	localparam logic FRU_DEST_ACC = 1'b0;
	localparam logic FRU_DEST_LOC = 1'b1;

	typedef enum logic [2:0] {
		FRU_OP_NONE,
		FRU_OP_COMPLEMENT_LOCATION,
		FRU_OP_CLEAR_LOCATION,
		FRU_OP_CLEAR_ACCUMULATOR,
		FRU_OP_DECREMENT_LOCATION,
		FRU_OP_DECREMENT_SKIP_ZERO,
		FRU_OP_INCREMENT_SKIP_ZERO
	} fru_op_t;

	typedef struct packed {
		fru_op_t op;
		logic [6:0] addr;
		logic dest;
	} fru_instr_t;

	typedef struct packed {
		logic acc_we;
		logic loc_we;
		logic [6:0] addr;
		logic [7:0] data;
	} fru_wb_t;

endpackage : fru_pkg

// ==== verilog/fru_data_mem.sv ====
// Data memory of 128 bytes, registered read, one write port.
// Assumes read and write addresses come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module fru_data_mem (
	input wire logic clk,
	input wire logic we,
	input wire logic [fru_pkg::FRU_ADDR_W-1:0] waddr,
	input wire logic [fru_pkg::FRU_DATA_W-1:0] wdata,
	input wire logic [fru_pkg::FRU_ADDR_W-1:0] raddr,
	output logic [fru_pkg::FRU_DATA_W-1:0] rdata
);
	import fru_pkg::*;

	logic [FRU_DATA_W-1:0] mem [FRU_MEM_DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// No write-through: a same-cycle write shows on the next read
	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
	end
endmodule // fru_data_mem
`default_nettype wire

// ==== verilog/fru_unary_ops.sv ====
// Execution datapath for single-operand data-memory instructions.
// Assumes the decoder presents one instruction per cycle with instr_valid,
// and that the sequencer honours skip_next by issuing a no-operation.
//
// Summary of operation
// - Complement invert location, update zero flag
// - Destination bit: 0 accumulator, 1 location
// - Clear location writes zero, sets zero flag
// - Decrement location to destination, update zero
// - Clear accumulator to zero, set zero flag
// - Decrement-skip: no flags, skip on zero
// - Increment-skip: no flags, skip on zero
// - Nonzero result no skip; 8-bit wrap
`timescale 1ns/1ps
`default_nettype none
module fru_unary_ops (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire fru_pkg::fru_instr_t instr,
	output fru_pkg::fru_wb_t wb,
	output logic [fru_pkg::FRU_DATA_W-1:0] acc,
	output logic zero_flag,
	output logic skip_next,
	output logic done
);
	import fru_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Stage 1: issue read, stage 2: execute with registered operand

	fru_instr_t ex_instr;
	logic ex_valid;
	logic [FRU_DATA_W-1:0] operand;
	logic [FRU_DATA_W-1:0] result;
	logic mem_we;

	function automatic logic is_zero(input logic [FRU_DATA_W-1:0] v);
		is_zero = (v == FRU_ZERO_BYTE);
	endfunction

	always_ff @(posedge clk) begin
		if (rst) begin
			ex_valid <= 1'b0;
			ex_instr <= '{op: FRU_OP_NONE, addr: '0, dest: FRU_DEST_ACC};
		end else begin
			ex_valid <= instr_valid;
			ex_instr <= instr;
		end
	end

	fru_data_mem u_mem (
		.clk(clk),
		.we(mem_we),
		.waddr(ex_instr.addr),
		.wdata(result),
		.raddr(instr.addr),
		.rdata(operand)
	);

	////////////////////////////////////////////////////////////////////////
	// Result and steering

	logic to_acc;
	logic to_loc;
	logic upd_zero;
	logic force_zero;
	logic is_skip;

	always_comb begin
		result = operand;
		to_acc = 1'b0;
		to_loc = 1'b0;
		upd_zero = 1'b0;
		force_zero = 1'b0;
		is_skip = 1'b0;
		unique case (ex_instr.op)
			FRU_OP_NONE: begin
			end
			FRU_OP_COMPLEMENT_LOCATION: begin
				result = ~operand;
				upd_zero = 1'b1;
			end
			FRU_OP_CLEAR_LOCATION: begin
				result = FRU_ZERO_BYTE;
				to_loc = 1'b1;
				force_zero = 1'b1;
			end
			FRU_OP_CLEAR_ACCUMULATOR: begin
				result = FRU_ZERO_BYTE;
				to_acc = 1'b1;
				force_zero = 1'b1;
			end
			FRU_OP_DECREMENT_LOCATION: begin
				result = operand - FRU_ONE_BYTE;
				upd_zero = 1'b1;
			end
			FRU_OP_DECREMENT_SKIP_ZERO: begin
				result = operand - FRU_ONE_BYTE;
				is_skip = 1'b1;
			end
			FRU_OP_INCREMENT_SKIP_ZERO: begin
				result = operand + FRU_ONE_BYTE;
				is_skip = 1'b1;
			end
			default: begin
			end
		endcase
		// Clear instructions have fixed targets and FRU_OP_NONE writes nothing; the rest follow dest
		if (!force_zero && ex_instr.op != FRU_OP_NONE) begin
			to_acc = (ex_instr.dest == FRU_DEST_ACC);
			to_loc = (ex_instr.dest == FRU_DEST_LOC);
		end
		if (!ex_valid) begin
			to_acc = 1'b0;
			to_loc = 1'b0;
			upd_zero = 1'b0;
			force_zero = 1'b0;
			is_skip = 1'b0;
		end
	end

	assign mem_we = to_loc;

	////////////////////////////////////////////////////////////////////////
	// Architectural state

	always_ff @(posedge clk) begin
		if (rst) begin
			acc <= FRU_ACC_RESET;
		end else if (to_acc) begin
			acc <= result;
		end
	end

	// Skip instructions leave the flag alone
	always_ff @(posedge clk) begin
		if (rst) begin
			zero_flag <= FRU_ZERO_FLAG_RESET;
		end else if (force_zero) begin
			zero_flag <= 1'b1;
		end else if (upd_zero) begin
			zero_flag <= is_zero(result);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			skip_next <= 1'b0;
		end else begin
			skip_next <= is_skip && is_zero(result);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wb <= '{acc_we: 1'b0, loc_we: 1'b0, addr: '0, data: FRU_ZERO_BYTE};
			done <= 1'b0;
		end else begin
			wb <= '{acc_we: to_acc, loc_we: to_loc, addr: ex_instr.addr, data: result};
			done <= ex_valid;
		end
	end
endmodule // fru_unary_ops
`default_nettype wire

// ==== tb/fru_seq_model.sv ====
// Sequencer model; assumes requests come from the bench.
`timescale 1ns/1ps
`default_nettype none
module fru_seq_model (
	input wire logic skip_next,
	input wire logic req_valid,
	input wire fru_pkg::fru_instr_t req,
	output logic instr_valid,
	output fru_pkg::fru_instr_t instr
);
	import fru_pkg::*;
	// Skipped slot becomes a no-op
	assign instr_valid = req_valid && !skip_next;
	assign instr = req;
endmodule // fru_seq_model
`default_nettype wire

// ==== tb/fru_assertions.sv ====
// Port checker; assumes one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module fru_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire fru_pkg::fru_instr_t instr,
	input wire fru_pkg::fru_wb_t wb,
	input wire logic [7:0] acc,
	input wire logic zero_flag,
	input wire logic skip_next,
	input wire logic done
);
	import fru_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_op(fru_op_t o);
		instr_valid && instr.op == o;
	endsequence
	sequence s_skip;
		s_op(FRU_OP_DECREMENT_SKIP_ZERO) or s_op(FRU_OP_INCREMENT_SKIP_ZERO);
	endsequence
	a_done_two_edges: assert property (instr_valid |-> ##2 done) else $error("no done");
	a_clr_acc_zero: assert property (
		s_op(FRU_OP_CLEAR_ACCUMULATOR) |-> ##2 acc == 8'h00 && zero_flag) else $error("clear acc");
	a_clr_loc_zero: assert property (
		s_op(FRU_OP_CLEAR_LOCATION) |-> ##2 wb.loc_we && wb.data == 8'h00 && zero_flag)
		else $error("clear loc");
	a_skip_keeps_z: assert property (s_skip |-> ##2 $stable(zero_flag)) else $error("z moved");
	a_skip_on_zero: assert property (
		s_skip ##2 wb.data == 8'h00 |-> skip_next) else $error("no skip");
	a_skip_needs_zero: assert property (
		skip_next |-> done && wb.data == 8'h00) else $error("bad skip");
	a_z_from_result: assert property (
		(s_op(FRU_OP_COMPLEMENT_LOCATION) or s_op(FRU_OP_DECREMENT_LOCATION))
		|-> ##2 zero_flag == (wb.data == 8'h00)) else $error("bad z");
	a_dest_route: assert property (
		s_op(FRU_OP_DECREMENT_LOCATION) ##2 done |-> wb.loc_we == $past(instr.dest, 2)
		&& wb.acc_we == !wb.loc_we) else $error("bad dest");
endmodule // fru_chk
bind fru_unary_ops fru_chk chk (.*);
`default_nettype wire

// ==== tb/fru_unary_ops_bench.sv ====
// Bench; assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module fru_unary_ops_bench;
	import fru_pkg::*;
	logic clk = 0, rst = 1, req_valid = 0, instr_valid, skip_next, done, zero_flag;
	fru_instr_t req = '0, instr;
	fru_wb_t wb;
	logic [7:0] acc;
	int error_cnt = 0, checks_done = 0;
	always #2 clk = ~clk;
	fru_seq_model seq (.*);
	fru_unary_ops uut (.*);
	task automatic results;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(logic [11:0] got, logic [11:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Gap before issue keeps read-after-write safe
	task automatic run(fru_op_t o, logic d, logic [7:0] x, logic z, logic s);
		int n;
		@(negedge clk);
		req = '{o, 7'h05, d};
		req_valid = 1;
		@(negedge clk);
		req_valid = 0;
		for (n = 0; n < 8 && done !== 1'b1; n++) @(negedge clk);
		if (n == 8) begin
			error_cnt++;
			results();
		end
		chk({wb.data, zero_flag, skip_next, wb.acc_we, wb.loc_we}, {x, z, s, !d, d});
		if (wb.acc_we === 1'b1) chk({4'h0, acc}, {4'h0, x});
	endtask
	// Request lands in the skipped slot and must be dropped
	task automatic skip_slot;
		int n;
		run(FRU_OP_DECREMENT_SKIP_ZERO, 1, 8'h00, 0, 1);
		req = '{FRU_OP_CLEAR_ACCUMULATOR, 7'h05, 1'b0};
		req_valid = 1;
		@(negedge clk);
		req_valid = 0;
		for (n = 0; n < 4; n++) begin
			@(negedge clk);
			chk({11'h000, done}, 12'h000);
		end
		chk({4'h0, acc}, 12'h0ff);
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst = 0;
		run(FRU_OP_CLEAR_ACCUMULATOR, 0, 8'h00, 1, 0);
		run(FRU_OP_CLEAR_LOCATION, 1, 8'h00, 1, 0);
		run(FRU_OP_INCREMENT_SKIP_ZERO, 1, 8'h01, 1, 0);
		run(FRU_OP_DECREMENT_LOCATION, 0, 8'h00, 1, 0);
		run(FRU_OP_DECREMENT_SKIP_ZERO, 1, 8'h00, 1, 1);
		run(FRU_OP_COMPLEMENT_LOCATION, 1, 8'hff, 0, 0);
		run(FRU_OP_INCREMENT_SKIP_ZERO, 1, 8'h00, 0, 1);
		run(FRU_OP_COMPLEMENT_LOCATION, 0, 8'hff, 0, 0);
		run(FRU_OP_DECREMENT_SKIP_ZERO, 0, 8'hff, 0, 0);
		run(FRU_OP_INCREMENT_SKIP_ZERO, 1, 8'h01, 0, 0);
		skip_slot();
		results();
	end
endmodule // fru_unary_ops_bench
`default_nettype wire
